// ===== bench/ext_bus_asserts.sv
/*
  checker for the external bus unit: select, strobe, state and release relations.
  assumes it is bound to external_bus_unit and sees only its ports.
*/
`timescale 1ns/1ps
module ext_bus_asserts
  import ext_bus_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [2:0] op_mode,
  input wire logic wide_space,
  input wire logic acc_done,
  input wire logic [EXT_ADDR_W-1:0] ext_addr,
  input wire logic ext_data_upper_oe,
  input wire logic ext_data_lower_oe,
  input wire strobe_bundle_t strobes,
  input wire logic release_request_n,
  input wire logic release_ack_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // area decode and active-high views
  wire [2:0] area = wide_space ? ext_addr[23:21] : ext_addr[19:17];
  wire [7:0] sel = ~strobes.area_select_n;
  wire as_on = !strobes.addr_valid_strobe_n;
  // an access keeps its strobe for at least two states
  sequence two_states;
    as_on [*2];
  endsequence
  sequence strobe_ended;
    !as_on ##0 $past(as_on);
  endsequence
  AST_ONE_SEL:
    assert property ($onehot0(sel)) else $error("more than one select low");
  AST_SEL_AREA:
    assert property (sel != 0 |-> sel == 8'h01 << area) else $error("select off area");
  AST_AS_SEL:
    assert property (as_on == (sel != 0)) else $error("address strobe apart from select");
  AST_READ:
    assert property (!strobes.read_n |-> as_on && strobes.upper_byte_write_n
      && strobes.lower_byte_write_n) else $error("read strobe outside read");
  AST_UPPER:
    assert property (!strobes.upper_byte_write_n |-> ext_data_upper_oe && as_on)
      else $error("upper write without upper data");
  AST_LOWER:
    assert property (!strobes.lower_byte_write_n |-> ext_data_lower_oe && as_on)
      else $error("lower write without lower data");
  AST_TWO_STATES:
    assert property ($rose(as_on) |-> two_states) else $error("access under two states");
  AST_DONE:
    assert property (acc_done |-> strobe_ended) else $error("done without ended strobe");
  AST_SINGLE:
    assert property (op_mode >= MODE_6 |-> sel == 0 && !acc_done)
      else $error("external access in single chip mode");
  AST_ACK_FREE:
    assert property (!release_ack_n |-> !as_on && sel == 0) else $error("driving while released");
  AST_ACK_DROP:
    assert property ($rose(release_request_n) |=> release_ack_n) else $error("ack kept");
endmodule : ext_bus_asserts

bind external_bus_unit ext_bus_asserts chk_i (.ref_clk, .nrst, .op_mode, .wide_space,
  .acc_done, .ext_addr, .ext_data_upper_oe, .ext_data_lower_oe, .strobes,
  .release_request_n, .release_ack_n);

// ===== bench/ext_mem_model.sv
/*
  far side model: external memory with optional pin waits and an external bus master.
  assumes strobes and address come registered from the external bus unit.
*/
`timescale 1ns/1ps
module ext_mem_model
  import ext_bus_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [EXT_ADDR_W-1:0] ext_addr,
  input wire strobe_bundle_t strobes,
  input wire logic slow,
  input wire logic want_bus,
  output logic [15:0] ext_data_in,
  output logic wait_req_n,
  output logic release_request_n
);
  logic [2:0] wcnt;
  logic [15:0] last = 16'h0000;
  // states since the address strobe fell; last bus value for junk
  always_ff @(posedge ref_clk) begin
    wcnt <= strobes.addr_valid_strobe_n ? 3'h0 : (wcnt == 3'h7 ? wcnt : wcnt + 3'h1);
    last <= ext_data_in;
  end
  // data from address while read, otherwise a changing pattern
  assign ext_data_in = !strobes.read_n ? ext_addr[15:0] ^ 16'h5a5a : ~last;
  assign wait_req_n = !(slow && !strobes.addr_valid_strobe_n && wcnt < 3'h4);
  assign release_request_n = !want_bus;
endmodule : ext_mem_model

// ===== bench/tb_top.sv
/*
  self-checking bench of the external bus unit: registers, states, waits, selects, idle, release.
  assumes the checker is bound and the far side is ext_mem_model.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top
  import ext_bus_pkg::*;
;
  logic ref_clk = 0, nrst = 0, wide_space = 0, standby_n = 1, reg_wr = 0, reg_rd = 0;
  logic acc_valid = 0, slow = 0, want_bus = 0, acc_done, ext_data_upper_oe, ext_data_lower_oe;
  logic wait_req_n, release_request_n, release_ack_n, bus_mode_8bit, port4_free;
  logic [2:0] op_mode = 3'h1;
  logic [19:0] reg_addr = 20'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, sel_lo;
  logic [15:0] acc_rdata, ext_data_out, ext_data_in;
  logic [23:0] ext_addr;
  access_req_t acc_req = '0;
  strobe_bundle_t strobes;
  logic up_s, lo_s, rd_s;
  int fail_count = 0, checked = 0, cyc = 0, n_as, n_tot, t0;
  localparam logic [19:0] REG_OFS [8] = '{OFS_BUS_RELEASE, OFS_ADDR_CTRL, OFS_CS_CTRL,
    OFS_WIDTH, OFS_STATE, OFS_WAIT_HI, OFS_WAIT_LO, OFS_GEN_CTRL};
  localparam logic [7:0] REG_RST [8] = '{8'hfe, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hc6};
  external_bus_unit external_bus_unit_i (.ref_clk, .nrst, .op_mode, .wide_space, .standby_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .acc_valid, .acc_req, .acc_done,
    .acc_rdata, .ext_addr, .ext_data_out, .ext_data_upper_oe, .ext_data_lower_oe, .ext_data_in,
    .strobes, .wait_req_n, .release_request_n, .release_ack_n, .bus_mode_8bit, .port4_free);
  ext_mem_model ext_mem_model_i (.ref_clk, .ext_addr, .strobes, .slow, .want_bus, .ext_data_in,
    .wait_req_n, .release_request_n);
  // clock and hang guard
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [19:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    `CHK(reg_rdata, e)
  endtask : rd
  // one access; counts strobe states and total cycles, gathers strobes seen
  task automatic acc(input logic [23:0] a, input logic w, input logic [1:0] be);
    n_as = 0;
    n_tot = 0;
    {sel_lo, up_s, lo_s, rd_s} = '0;
    @(posedge ref_clk);
    acc_req <= '{a, w, be[1], be[0], ~a[15:0]};
    acc_valid <= 1'b1;
    do begin
      @(negedge ref_clk);
      n_tot++;
      n_as += !strobes.addr_valid_strobe_n;
      sel_lo |= ~strobes.area_select_n;
      up_s |= !strobes.upper_byte_write_n;
      lo_s |= !strobes.lower_byte_write_n;
      rd_s |= !strobes.read_n;
    end while (acc_done !== 1'b1 && n_tot < 40);
    @(posedge ref_clk);
    acc_valid <= 1'b0;
  endtask : acc
  task automatic t_regs();
    for (int i = 0; i < 8; i++) rd(REG_OFS[i], REG_RST[i]);
    `CHK({bus_mode_8bit, port4_free}, 2'b11)
    for (int i = 0; i < 8; i++) wr(REG_OFS[i], 8'h5a ^ i[7:0]);
    for (int i = 0; i < 8; i++) rd(REG_OFS[i], 8'h5a ^ i[7:0]);
    rd(20'hee000, 8'h00);
    op_mode <= MODE_4;
    @(posedge ref_clk) standby_n <= 1'b0;
    @(posedge ref_clk) standby_n <= 1'b1;
    rd(OFS_WIDTH, 8'h00);
    rd(OFS_BUS_RELEASE, 8'hee);
    rd(OFS_STATE, 8'hff);
    rd(OFS_WAIT_LO, 8'hff);
    `CHK(bus_mode_8bit, 1'b0)
    $display("regs done");
  endtask : t_regs
  task automatic t_states();
    wr(OFS_STATE, 8'h00);
    acc(24'h000010, 1'b0, 2'd3);
    `CHK(n_as, 2)
    `CHK(acc_rdata, 16'h0010 ^ 16'h5a5a)
    wr(OFS_STATE, 8'hff);
    for (int c = 0; c < 4; c++) begin
      wr(OFS_WAIT_HI, {4'hf, c[1:0], 2'h3});
      acc(24'h0a0000, 1'b0, 2'd3);
      `CHK(n_as, 3 + c)
    end
    wr(OFS_WAIT_LO, 8'hf3);
    acc(24'h020000, 1'b0, 2'd3);
    `CHK(n_as, 3)
    acc(24'h000000, 1'b0, 2'd3);
    `CHK(n_as, 6)
    $display("states done");
  endtask : t_states
  task automatic t_pin();
    wr(OFS_WAIT_LO, 8'h00);
    slow <= 1'b1;
    acc(24'h000000, 1'b0, 2'd3);
    `CHK(n_as > 3, 1'b1)
    wr(OFS_STATE, 8'h00);
    acc(24'h000000, 1'b0, 2'd3);
    `CHK(n_as, 2)
    slow <= 1'b0;
    $display("pin wait done");
  endtask : t_pin
  task automatic t_sel();
    wr(OFS_CS_CTRL, 8'hff);
    for (int i = 0; i < 8; i++) begin
      acc({4'h0, i[2:0], 17'h0}, 1'b0, 2'd3);
      `CHK({sel_lo, rd_s}, {8'h01 << i, 1'b1})
    end
    wide_space <= 1'b1;
    acc(24'hc00000, 1'b0, 2'd3);
    `CHK(sel_lo, 8'h40)
    wide_space <= 1'b0;
    $display("selects done");
  endtask : t_sel
  task automatic t_idle();
    acc(24'h0, 1'b0, 2'd3);
    acc(24'h0, 1'b0, 2'd3);
    t0 = n_tot;
    acc(24'h020000, 1'b0, 2'd3);
    `CHK(n_tot, t0 + 1)
    acc(24'h0, 1'b0, 2'd3);
    acc(24'h0, 1'b1, 2'd3);
    t0 = n_tot;
    `CHK({up_s, lo_s, rd_s}, 3'b110)
    wr(OFS_GEN_CTRL, 8'hc7);
    acc(24'h0, 1'b0, 2'd3);
    acc(24'h0, 1'b1, 2'd1);
    `CHK(n_tot, t0 + 1)
    `CHK({up_s, lo_s}, 2'b01)
    $display("idle done");
  endtask : t_idle
  task automatic t_rel();
    want_bus <= 1'b1;
    repeat (3) @(posedge ref_clk);
    `CHK(release_ack_n, 1'b1)
    wr(OFS_BUS_RELEASE, 8'hef);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk) `CHK(release_ack_n, 1'b0)
    `CHK(strobes, {8'hff, 4'hf})
    @(posedge ref_clk) want_bus <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk) `CHK(release_ack_n, 1'b1)
    $display("release done");
  endtask : t_rel
  task automatic t_single();
    op_mode <= MODE_6;
    acc(24'h0, 1'b0, 2'd3);
    `CHK({n_tot, n_as}, {32'd40, 32'd0})
    op_mode <= MODE_4;
    $display("single chip done");
  endtask : t_single
  task automatic wrap_up();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    t_states();
    t_pin();
    t_sel();
    t_idle();
    t_rel();
    t_single();
    wrap_up();
  end
endmodule : tb_top

// ===== src/ext_bus_pkg.sv
/*
  shared constants and types of the external bus unit: register offsets, reset values,
  mode codes, field layouts, access request and strobe bundles.
  assumes a byte-wide register port with 20-bit register addresses.
*/
package ext_bus_pkg;
  localparam int unsigned AREA_COUNT = 8;
  localparam int unsigned REG_ADDR_W = 20;
  localparam int unsigned EXT_ADDR_W = 24;
  // register offsets
  localparam logic [19:0] OFS_BUS_RELEASE = 20'hee013;
  localparam logic [19:0] OFS_ADDR_CTRL = 20'hee01e;
  localparam logic [19:0] OFS_CS_CTRL = 20'hee01f;
  localparam logic [19:0] OFS_WIDTH = 20'hee020;
  localparam logic [19:0] OFS_STATE = 20'hee021;
  localparam logic [19:0] OFS_WAIT_HI = 20'hee022;
  localparam logic [19:0] OFS_WAIT_LO = 20'hee023;
  localparam logic [19:0] OFS_GEN_CTRL = 20'hee024;
  // reset values
  localparam logic [7:0] RST_ALL_ONES = 8'hff;
  localparam logic [7:0] RST_WIDTH_16 = 8'h00;
  localparam logic [7:0] RST_RELEASE = 8'hfe;
  localparam logic [7:0] RST_RELEASE_M34 = 8'hee;
  localparam logic [7:0] RST_CS_CTRL = 8'h0f;
  localparam logic [7:0] RST_GEN_CTRL = 8'hc6;
  // bus release control: bit 0 enables the release handshake
  localparam int unsigned REL_ENABLE_BIT = 0;
  // general control: bits 1 and 0 enable idle insertion
  localparam int unsigned IDLE_AREA_BIT = 1;
  localparam int unsigned IDLE_RW_BIT = 0;
  // area index sits in address bits 19:17 (1M) or 23:21 (16M)
  localparam int unsigned AREA_LSB_1M = 17;
  localparam int unsigned AREA_LSB_16M = 21;
  localparam int unsigned AREA_W = 3;
  localparam logic [3:0] BASE_STATES = 4'h2;
  localparam logic [2:0] MODE_2 = 3'h2;
  localparam logic [2:0] MODE_3 = 3'h3;
  localparam logic [2:0] MODE_4 = 3'h4;
  localparam logic [2:0] MODE_6 = 3'h6;
  localparam logic [2:0] MODE_7 = 3'h7;

  typedef struct packed {
    logic [EXT_ADDR_W-1:0] addr;
    logic write;
    logic upper_en;
    logic lower_en;
    logic [15:0] wdata;
  } access_req_t;

  typedef struct packed {
    logic [AREA_COUNT-1:0] area_select_n;
    logic addr_valid_strobe_n;
    logic read_n;
    logic upper_byte_write_n;
    logic lower_byte_write_n;
  } strobe_bundle_t;
endpackage : ext_bus_pkg

// ===== src/external_bus_unit.sv
/*
  external bus unit: area decode, chip selects, per-area width, state count and program
  waits, idle insertion and external bus release.
  assumes mode pins stable after reset, synchronous pins, and an internal master that holds
  its request until the done pulse.
*/
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module external_bus_unit
  import ext_bus_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [2:0] op_mode,
  input wire logic wide_space,
  input wire logic standby_n,
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic acc_valid,
  input wire access_req_t acc_req,
  output logic acc_done,
  output logic [15:0] acc_rdata,
  output logic [EXT_ADDR_W-1:0] ext_addr,
  output logic [15:0] ext_data_out,
  output logic ext_data_upper_oe,
  output logic ext_data_lower_oe,
  input wire logic [15:0] ext_data_in,
  output strobe_bundle_t strobes,
  input wire logic wait_req_n,
  input wire logic release_request_n,
  output logic release_ack_n,
  output logic bus_mode_8bit,
  output logic port4_free
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_GAP = 5'b00010,
    ST_T1 = 5'b00100,
    ST_T2 = 5'b01000,
    ST_T3 = 5'b10000
  } bus_state_t;
  // one-hot cycle states:
  // idle - no external cycle, strobes high
  // gap - inserted idle state, nothing driven
  // t1 - first state, address and selects out
  // t2 - second state, write strobes out
  // t3 - third state, program and pin waits
  // pin notes:
  // - all strobes are active low and registered
  // - data enables are high while the unit drives the lines
  // - ext_data_out holds its last value between writes
  // - acc_rdata holds until the next cycle completes
  // - bus_mode_8bit and port4_free follow the width register
  //   and the mode pins without a register stage
  // - release_ack_n is low while the outside master owns the bus
  // reset notes:
  // - all registers take their plain reset values on nrst low
  // - mode values for width and release follow one edge later
  // - hardware standby low reloads every register each cycle
  // - strobes are high and enables low throughout reset

  logic [7:0] width_reg, state_reg, wait_hi_reg, wait_lo_reg;
  logic [7:0] release_reg, addr_ctrl_reg, cs_ctrl_reg, gen_ctrl_reg;
  bus_state_t st_reg, st_next;
  logic [3:0] wcnt_reg;
  logic last_read_reg;
  logic [AREA_W-1:0] last_area_reg;
  logic ack_reg;
  logic [AREA_W-1:0] cur_area;
  logic cur_3state, cur_8bit, need_idle, ext_mode;
  logic [1:0] cur_wait;
  logic strap_done_reg;
  // register file notes:
  // - all eight registers are byte wide and read back as written
  // - state and wait registers steer external cycles only; width also drives bus_mode_8bit
  // - address and chip select control are stored, not decoded here
  // - release register bit 0 gates the release handshake
  // - general control bits 1:0 gate the two idle insertions
  // sequencer notes:
  // - gap is the inserted idle state, no strobe is driven in it
  // - t1 and t2 are the two basic states of every external cycle
  // - t3 is the third state, repeated for each program wait
  // - pin waits stretch t3 only after the program waits ran out
  // program wait counter: loaded with the area's code as t2
  // ends, counts down once per t3; t3 ends when it is zero and
  // the wait pin is high; every area loads it, even though
  // two-state areas leave t2 straight to idle and never use it

  // area index of an address for the active space size;
  // bits above the area field are ignored, so areas repeat upward
  function automatic logic [AREA_W-1:0] area_of(input logic [EXT_ADDR_W-1:0] a,
                                                input logic wide);
    if (wide) begin
      area_of = a[AREA_LSB_16M +: AREA_W];
    end else begin
      area_of = a[AREA_LSB_1M +: AREA_W];
    end
  endfunction : area_of

  // two-bit wait code of an area; fields run from area 7 at
  // bits 15:14 down to area 0 at bits 1:0 of the joined registers
  function automatic logic [1:0] wait_code(input logic [AREA_W-1:0] ar,
                                           input logic [7:0] hi,
                                           input logic [7:0] lo);
    logic [15:0] both;
    both = {hi, lo};
    wait_code = both[{ar, 1'b0} +: 2];
  endfunction : wait_code

  // register write decode; hardware standby acts like reset.
  // the first edge after reset release also loads the mode values,
  // since the mode pins are only trusted once reset has gone;
  // software standby is not seen here, so contents are kept
  // through it; a write in the load cycle is lost on purpose
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      width_reg <= RST_ALL_ONES;
      state_reg <= RST_ALL_ONES;
      wait_hi_reg <= RST_ALL_ONES;
      wait_lo_reg <= RST_ALL_ONES;
      release_reg <= RST_RELEASE;
      addr_ctrl_reg <= RST_ALL_ONES;
      cs_ctrl_reg <= RST_CS_CTRL;
      gen_ctrl_reg <= RST_GEN_CTRL;
    end else if (!standby_n || !strap_done_reg) begin
      width_reg <= (op_mode == MODE_2 || op_mode == MODE_4) ? RST_WIDTH_16 : RST_ALL_ONES;
      state_reg <= RST_ALL_ONES;
      wait_hi_reg <= RST_ALL_ONES;
      wait_lo_reg <= RST_ALL_ONES;
      release_reg <= (op_mode == MODE_3 || op_mode == MODE_4) ? RST_RELEASE_M34 : RST_RELEASE;
      addr_ctrl_reg <= RST_ALL_ONES;
      cs_ctrl_reg <= RST_CS_CTRL;
      gen_ctrl_reg <= RST_GEN_CTRL;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_WIDTH: width_reg <= reg_wdata;
        OFS_STATE: state_reg <= reg_wdata;
        OFS_WAIT_HI: wait_hi_reg <= reg_wdata;
        OFS_WAIT_LO: wait_lo_reg <= reg_wdata;
        OFS_BUS_RELEASE: release_reg <= reg_wdata;
        OFS_ADDR_CTRL: addr_ctrl_reg <= reg_wdata;
        OFS_CS_CTRL: cs_ctrl_reg <= reg_wdata;
        OFS_GEN_CTRL: gen_ctrl_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // mode-dependent reset values are taken on the first edge after release;
  // the marker also holds off external cycles until that load is done
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      strap_done_reg <= 1'b0;
    end else begin
      strap_done_reg <= 1'b1;
    end
  end

  // read data, one cycle after the strobe; unmapped reads give zero;
  // the port returns to zero between reads so a stale byte never
  // looks like a fresh answer
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_WIDTH: reg_rdata <= width_reg;
        OFS_STATE: reg_rdata <= state_reg;
        OFS_WAIT_HI: reg_rdata <= wait_hi_reg;
        OFS_WAIT_LO: reg_rdata <= wait_lo_reg;
        OFS_BUS_RELEASE: reg_rdata <= release_reg;
        OFS_ADDR_CTRL: reg_rdata <= addr_ctrl_reg;
        OFS_CS_CTRL: reg_rdata <= cs_ctrl_reg;
        OFS_GEN_CTRL: reg_rdata <= gen_ctrl_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // settings of the area being addressed and the mode outputs; the area fields follow the
  // request address combinationally, so the request must stay put
  // until done; single-chip modes never start an external cycle
  always_comb begin
    ext_mode = (op_mode != MODE_6) && (op_mode != MODE_7);
    cur_area = area_of(acc_req.addr, wide_space);
    cur_3state = state_reg[cur_area];
    cur_8bit = width_reg[cur_area];
    cur_wait = wait_code(cur_area, wait_hi_reg, wait_lo_reg);
    need_idle = last_read_reg &&
                ((gen_ctrl_reg[IDLE_AREA_BIT] && last_area_reg != cur_area) ||
                 (gen_ctrl_reg[IDLE_RW_BIT] && acc_req.write));
    bus_mode_8bit = ext_mode && (width_reg == RST_ALL_ONES);
    port4_free = bus_mode_8bit;
  end

  // bus cycle sequencer; a new cycle may not start while done is
  // still showing, so a master that drops its request on seeing done
  // is never served twice; a granted release also blocks starts
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE: begin
        if (acc_valid && ext_mode && !ack_reg && strap_done_reg && !acc_done) begin
          st_next = need_idle ? ST_GAP : ST_T1;
        end
      end
      ST_GAP: st_next = ST_T1;
      ST_T1: st_next = ST_T2;
      ST_T2: begin
        if (cur_3state) begin
          st_next = ST_T3;
        end else begin
          st_next = ST_IDLE;
        end
      end
      ST_T3: begin
        if (wcnt_reg == 4'h0 && wait_req_n) begin
          st_next = ST_IDLE;
        end
      end
      default: st_next = ST_IDLE;
    endcase
  end

  // state, program wait counter and history of the last cycle;
  // the history is kept across idle gaps, which may insert an idle
  // state that was not strictly needed, but never misses one
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= ST_IDLE;
      wcnt_reg <= 4'h0;
      last_read_reg <= 1'b0;
      last_area_reg <= '0;
    end else begin
      st_reg <= st_next;
      if (st_reg == ST_T2) begin
        wcnt_reg <= {2'b00, cur_wait};
      end else if (st_reg == ST_T3 && wcnt_reg != 4'h0) begin
        wcnt_reg <= wcnt_reg - 4'h1;
      end
      if (st_next == ST_IDLE && st_reg != ST_IDLE && st_reg != ST_GAP) begin
        last_read_reg <= !acc_req.write;
        last_area_reg <= cur_area;
      end
    end
  end

  // external pins and done pulse, registered; strobes and address
  // move together on the same edge; write strobes wait for the
  // second state so that the data lines settle first; 8-bit areas
  // put the byte on the upper lines and leave the lower undriven
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ext_addr <= '0;
      ext_data_out <= 16'h0000;
      ext_data_upper_oe <= 1'b0;
      ext_data_lower_oe <= 1'b0;
      strobes <= '1;
      acc_done <= 1'b0;
      acc_rdata <= 16'h0000;
    end else begin
      acc_done <= 1'b0;
      strobes <= '1;
      ext_data_upper_oe <= 1'b0;
      ext_data_lower_oe <= 1'b0;
      if (st_next == ST_T1 || st_next == ST_T2 || st_next == ST_T3) begin
        ext_addr <= acc_req.addr;
        strobes.area_select_n <= ~(8'h01 << cur_area);
        strobes.addr_valid_strobe_n <= 1'b0;
        strobes.read_n <= acc_req.write;
        if (acc_req.write) begin
          ext_data_out <= cur_8bit ? {acc_req.wdata[7:0], 8'h00} : acc_req.wdata;
          ext_data_upper_oe <= 1'b1;
          ext_data_lower_oe <= !cur_8bit;
          if (st_next != ST_T1) begin
            strobes.upper_byte_write_n <= !(acc_req.upper_en || cur_8bit);
            strobes.lower_byte_write_n <= !(acc_req.lower_en && !cur_8bit);
          end
        end
      end
      if (st_reg != ST_IDLE && st_reg != ST_GAP && st_next == ST_IDLE) begin
        acc_done <= 1'b1;
        acc_rdata <= cur_8bit ? {8'h00, ext_data_in[15:8]} : ext_data_in;
      end
    end
  end

  // release to an outside master between cycles; the grant is only
  // given when no cycle starts on the same edge, so strobes and
  // acknowledge never overlap; dropping the request takes it back
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
    end else if (!release_request_n && release_reg[REL_ENABLE_BIT] && st_next == ST_IDLE) begin
      ack_reg <= 1'b1;
    end else if (release_request_n) begin
      ack_reg <= 1'b0;
    end
  end

  assign release_ack_n = !ack_reg;

  // timing of a two-state read, edge by edge:
  // e0: request seen while idle, t1 chosen, strobes fall after e0
  // e1: t2 entered, strobes stay low
  // e2: t2 left, read data captured, strobes rise, done set
  // e3: done shows, no new cycle is taken on this edge
  // e4: earliest edge at which the next request is taken
  // a three-state read adds one t3 edge, plus one per program wait
  // write cycles: data and enables from t1, write strobes from t2
  // idle insertion: one gap state before t1, nothing driven
  // release: request low while idle, grant on the next edge
  // hazards:
  // - the request bundle is not latched; it must stay stable
  // - mode pins are read every cycle, not only at reset
  // - the wait pin is taken as synchronous; an async source
  //   needs a synchroniser outside this block
  // - a request during release waits until the grant drops
  // limits:
  // - chip select and address control registers are storage only
  // - no address update modes are modelled
  // - standby reload takes one cycle with standby low
endmodule : external_bus_unit
